/* inc/cfgma_defines.vh */
// Constants of the configuration message interpreter: tokens, bank patterns, layout.
// Assumes a byte-wide token stream with a control flag per token.
// Notes on behaviour
// - Return low byte all ones: no reply to a successful write.
// - Multi-byte fields travel most significant first.
// - Status resource id is reg<<8 OR 0x0C.
// - Status read/write moves one full word.
// - Config write: 192, return, reg16, data32, 1.
// - Config read: 193, return, reg16, 1.
// - Write reply: 3,1 success; 4,1 failure.
// - Config read reply: 3, data32, 1; else 4,1.
// - Peripheral 36/37, return, reg8, size8, data (36 only), 1.
// - Peripheral read reply: 3, size bytes, 1.
`ifndef CFGMA_DEFINES_VH
`define CFGMA_DEFINES_VH
`define CFGMA_TOK_CFG_WR 8'hc0
`define CFGMA_TOK_CFG_RD 8'hc1
`define CFGMA_TOK_PER_WR 8'h24
`define CFGMA_TOK_PER_RD 8'h25
`define CFGMA_TOK_END 8'h01
`define CFGMA_TOK_ACK 8'h03
`define CFGMA_TOK_NAK 8'h04
`define CFGMA_DEST_TILE 16'hc20c
`define CFGMA_DEST_NODE 16'hc30c
`define CFGMA_DEST_PER 8'h02
`define CFGMA_NO_REPLY 8'hff
`define CFGMA_PS_LOW 16'h000c
`define CFGMA_PS_SHIFT 8
`define CFGMA_RET_BYTES 9'h003
`define CFGMA_WORD_BYTES 9'h004
`define CFGMA_CFG_REGS 16'h0010
`define CFGMA_PER_BYTES 9'h080
`define CFGMA_PER_BASE 8'h80
`define CFGMA_NODE_BASE 2'h1
`define CFGMA_TILE_BASE 2'h0
`define CFGMA_MEM_DEPTH 256
`define CFGMA_PS_REGS 4
`endif

/* src/cfgma_core.v */
// Configuration message interpreter: decodes access messages and sends replies.
// Assumes inputs synchronous to clk_i; rx_dest_i is stable from the leading token on.
module cfgma_core (
    input wire clk_i,
    input wire rst_n_i,
    input wire rx_valid_i,
    input wire rx_ctrl_i,
    input wire [7:0] rx_data_i,
    input wire [31:0] rx_dest_i,
    output wire rx_ready_o,
    output reg tx_valid_o,
    output reg tx_ctrl_o,
    output reg [7:0] tx_data_o,
    output reg [23:0] tx_dest_o,
    input wire tx_ready_i,
    input wire ps_valid_i,
    input wire ps_write_i,
    input wire [7:0] ps_reg_i,
    input wire [31:0] ps_wdata_i,
    output reg [15:0] ps_res_o,
    output reg [31:0] ps_rdata_o
);
`include "cfgma_defines.vh"

    localparam S_IDLE = 4'h0;
    localparam S_RET = 4'h1;
    localparam S_REG = 4'h2;
    localparam S_SIZE = 4'h3;
    localparam S_DATA = 4'h4;
    localparam S_END = 4'h5;
    localparam S_HDR = 4'h6;
    localparam S_RADDR = 4'h7;
    localparam S_RDAT = 4'h8;
    localparam S_RSEND = 4'h9;
    localparam S_TAIL = 4'ha;

    localparam OP_NONE = 2'h0;
    localparam OP_WR = 2'h1;
    localparam OP_RD = 2'h2;

    localparam BK_NONE = 2'h0;
    localparam BK_TILE = 2'h1;
    localparam BK_NODE = 2'h2;
    localparam BK_PER = 2'h3;

    reg [3:0] state;
    reg [1:0] op;
    reg [1:0] bank;
    reg [15:0] regn;
    reg [8:0] cnt;
    reg [7:0] addr;
    reg fail;
    reg [31:0] ps_regs [0:`CFGMA_PS_REGS-1];

    wire [7:0] mem_rdata;
    wire rx_tok = rx_valid_i && rx_ready_o;
    wire rx_byte = rx_tok && !rx_ctrl_i;
    wire mem_we = (state == S_DATA) && rx_byte && !fail;
    wire [15:0] next_regn = {regn[7:0], rx_data_i};

    // Bank from the channel-end destination the requester addressed.
    function [1:0] bank_of;
        input [31:0] dest;
        begin
            if (dest[15:0] == `CFGMA_DEST_TILE) begin
                bank_of = BK_TILE;
            end else if (dest[15:0] == `CFGMA_DEST_NODE) begin
                bank_of = BK_NODE;
            end else if (dest[7:0] == `CFGMA_DEST_PER) begin
                bank_of = BK_PER;
            end else begin
                bank_of = BK_NONE;
            end
        end
    endfunction

    // Byte address of the most significant byte of a tile or node word.
    function [7:0] word_addr;
        input [1:0] bk;
        input [15:0] r;
        begin
            if (bk == BK_NODE) begin
                word_addr = {`CFGMA_NODE_BASE, r[3:0], 2'b00};
            end else begin
                word_addr = {`CFGMA_TILE_BASE, r[3:0], 2'b00};
            end
        end
    endfunction

    assign rx_ready_o = (state <= S_END);

    cfgma_mem cfgma_mem_inst (
        .clk_i(clk_i),
        .we_i(mem_we),
        .waddr_i(addr),
        .wdata_i(rx_data_i),
        .raddr_i(addr),
        .rdata_o(mem_rdata)
    );

    // Processor-status access: one whole word each way.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            ps_res_o <= 16'h0000;
            ps_rdata_o <= 32'h0000_0000;
        end else if (ps_valid_i) begin
            ps_res_o <= ({ps_reg_i, 8'h00} | `CFGMA_PS_LOW);
            if (ps_write_i) begin
                ps_regs[ps_reg_i[1:0]] <= ps_wdata_i;
            end else begin
                ps_rdata_o <= ps_regs[ps_reg_i[1:0]];
            end
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= S_IDLE;
            op <= OP_NONE;
            bank <= BK_NONE;
            regn <= 16'h0000;
            cnt <= 9'h000;
            addr <= 8'h00;
            fail <= 1'b0;
            tx_valid_o <= 1'b0;
            tx_ctrl_o <= 1'b0;
            tx_data_o <= 8'h00;
            tx_dest_o <= 24'h000000;
        end else if (rx_tok && rx_ctrl_i && state != S_IDLE) begin
            // A control token inside a message either ends it or spoils it.
            if (rx_data_i == `CFGMA_TOK_END) begin
                if (op == OP_WR && !fail && state == S_END
                        && tx_dest_o[7:0] == `CFGMA_NO_REPLY) begin
                    state <= S_IDLE;
                end else begin
                    state <= S_HDR;
                    tx_valid_o <= 1'b1;
                    tx_ctrl_o <= 1'b1;
                    if (fail || state != S_END) begin
                        fail <= 1'b1;
                        tx_data_o <= `CFGMA_TOK_NAK;
                    end else begin
                        tx_data_o <= `CFGMA_TOK_ACK;
                    end
                end
            end else begin
                fail <= 1'b1;
            end
        end else begin
            case (state)
                S_IDLE: begin
                    if (rx_tok && rx_ctrl_i) begin
                        fail <= 1'b0;
                        cnt <= `CFGMA_RET_BYTES;
                        state <= S_RET;
                        if (rx_data_i == `CFGMA_TOK_CFG_WR) begin
                            op <= OP_WR;
                            bank <= bank_of(rx_dest_i);
                            if (bank_of(rx_dest_i) == BK_PER
                                    || bank_of(rx_dest_i) == BK_NONE) begin
                                fail <= 1'b1;
                            end
                        end else if (rx_data_i == `CFGMA_TOK_CFG_RD) begin
                            op <= OP_RD;
                            bank <= bank_of(rx_dest_i);
                            if (bank_of(rx_dest_i) == BK_PER
                                    || bank_of(rx_dest_i) == BK_NONE) begin
                                fail <= 1'b1;
                            end
                        end else if (rx_data_i == `CFGMA_TOK_PER_WR
                                || rx_data_i == `CFGMA_TOK_PER_RD) begin
                            op <= (rx_data_i == `CFGMA_TOK_PER_WR) ? OP_WR : OP_RD;
                            bank <= bank_of(rx_dest_i);
                            if (bank_of(rx_dest_i) != BK_PER) begin
                                fail <= 1'b1;
                            end
                        end else begin
                            op <= OP_NONE;
                            bank <= BK_NONE;
                            fail <= 1'b1;
                        end
                    end
                end
                S_RET: begin
                    if (rx_byte) begin
                        tx_dest_o <= {tx_dest_o[15:0], rx_data_i};
                        cnt <= cnt - 9'h001;
                        if (cnt == 9'h001) begin
                            regn <= 16'h0000;
                            if (op == OP_NONE) begin
                                state <= S_END;
                            end else begin
                                state <= S_REG;
                                cnt <= (bank == BK_PER) ? 9'h001 : 9'h002;
                            end
                        end
                    end
                end
                S_REG: begin
                    if (rx_byte) begin
                        regn <= next_regn;
                        cnt <= cnt - 9'h001;
                        if (cnt == 9'h001) begin
                            if (bank == BK_PER) begin
                                state <= S_SIZE;
                            end else begin
                                addr <= word_addr(bank, next_regn);
                                cnt <= `CFGMA_WORD_BYTES;
                                if (next_regn >= `CFGMA_CFG_REGS) begin
                                    fail <= 1'b1;
                                end
                                state <= (op == OP_WR) ? S_DATA : S_END;
                            end
                        end
                    end
                end
                S_SIZE: begin
                    if (rx_byte) begin
                        addr <= `CFGMA_PER_BASE + regn[7:0];
                        cnt <= {1'b0, rx_data_i};
                        if ({1'b0, regn[7:0]} + {1'b0, rx_data_i} > `CFGMA_PER_BYTES) begin
                            fail <= 1'b1;
                        end
                        if (op == OP_WR && rx_data_i != 8'h00) begin
                            state <= S_DATA;
                        end else begin
                            state <= S_END;
                        end
                    end
                end
                S_DATA: begin
                    if (rx_byte) begin
                        addr <= addr + 8'h01;
                        cnt <= cnt - 9'h001;
                        if (cnt == 9'h001) begin
                            state <= S_END;
                        end
                    end
                end
                S_END: begin
                    if (rx_byte) begin
                        fail <= 1'b1;
                    end
                end
                S_HDR: begin
                    if (tx_ready_i) begin
                        if (!fail && op == OP_RD && cnt != 9'h000) begin
                            tx_valid_o <= 1'b0;
                            state <= S_RADDR;
                        end else begin
                            tx_data_o <= `CFGMA_TOK_END;
                            state <= S_TAIL;
                        end
                    end
                end
                S_RADDR: begin
                    state <= S_RDAT;
                end
                S_RDAT: begin
                    tx_valid_o <= 1'b1;
                    tx_ctrl_o <= 1'b0;
                    tx_data_o <= mem_rdata;
                    state <= S_RSEND;
                end
                S_RSEND: begin
                    if (tx_ready_i) begin
                        addr <= addr + 8'h01;
                        cnt <= cnt - 9'h001;
                        if (cnt == 9'h001) begin
                            tx_ctrl_o <= 1'b1;
                            tx_data_o <= `CFGMA_TOK_END;
                            state <= S_TAIL;
                        end else begin
                            tx_valid_o <= 1'b0;
                            state <= S_RADDR;
                        end
                    end
                end
                S_TAIL: begin
                    if (tx_ready_i) begin
                        tx_valid_o <= 1'b0;
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // cfgma_core

/* src/cfgma_mem.v */
// Byte-wide register store for the tile, node and peripheral banks.
// Assumes one write port and one read port; read data appear one clock after the address.
module cfgma_mem (
    input wire clk_i,
    input wire we_i,
    input wire [7:0] waddr_i,
    input wire [7:0] wdata_i,
    input wire [7:0] raddr_i,
    output reg [7:0] rdata_o
);
`include "cfgma_defines.vh"

    reg [7:0] mem [0:`CFGMA_MEM_DEPTH-1];

    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule // cfgma_mem

/* tb/cfgma_core_properties.sv */
// Concurrent checks on the ports of the message interpreter core.
// Assumes one clock domain with a synchronous active-low reset.
module cfgma_core_properties (
    input wire clk_i,
    input wire rst_n_i,
    input wire rx_valid_i,
    input wire rx_ctrl_i,
    input wire [7:0] rx_data_i,
    input wire rx_ready_o,
    input wire tx_valid_o,
    input wire tx_ctrl_o,
    input wire [7:0] tx_data_o,
    input wire [23:0] tx_dest_o,
    input wire tx_ready_i,
    input wire ps_valid_i,
    input wire ps_write_i,
    input wire [7:0] ps_reg_i,
    input wire [31:0] ps_wdata_i,
    input wire [15:0] ps_res_o,
    input wire [31:0] ps_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic first;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // High when the next reply token taken is a header.
    always_ff @(posedge clk_i)
        if (!rst_n_i) first <= 1'b1;
        else if (tx_valid_o && tx_ready_i) first <= tx_ctrl_o && tx_data_o == 8'h01;
    busy_ready_a: assert property (tx_valid_o |-> !rx_ready_o)
        else $error("request accepted during a reply");
    reply_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o &&
        $stable({tx_ctrl_o, tx_data_o, tx_dest_o})) else $error("reply token not held");
    head_code_a: assert property (tx_valid_o && first |->
        tx_ctrl_o && (tx_data_o == 8'h03 || tx_data_o == 8'h04)) else $error("bad header");
    head_time_a: assert property ($rose(tx_valid_o) && first |->
        $past(rx_valid_i && rx_ready_o && rx_ctrl_i && rx_data_i == 8'h01))
        else $error("header not after end token");
    nak_tail_a: assert property (tx_valid_o && tx_ready_i && first && tx_data_o == 8'h04
        |=> tx_valid_o && tx_ctrl_o && tx_data_o == 8'h01) else $error("no tail");
    data_flag_a: assert property (tx_valid_o && !tx_ctrl_o |-> !first)
        else $error("data byte before header");
    ps_res_a: assert property (ps_valid_i |=> ps_res_o == {$past(ps_reg_i), 8'h0c})
        else $error("bad status resource id");
    ps_word_a: assert property (ps_valid_i && ps_write_i ##1 ps_valid_i && !ps_write_i &&
        ps_reg_i == $past(ps_reg_i) |=> ps_rdata_o == $past(ps_wdata_i, 2))
        else $error("status word lost");
endmodule // cfgma_core_properties

bind cfgma_core cfgma_core_properties cfgma_core_properties_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .rx_valid_i(rx_valid_i), .rx_ctrl_i(rx_ctrl_i), .rx_data_i(rx_data_i),
    .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_ctrl_o(tx_ctrl_o),
    .tx_data_o(tx_data_o), .tx_dest_o(tx_dest_o), .tx_ready_i(tx_ready_i),
    .ps_valid_i(ps_valid_i), .ps_write_i(ps_write_i), .ps_reg_i(ps_reg_i),
    .ps_wdata_i(ps_wdata_i), .ps_res_o(ps_res_o), .ps_rdata_o(ps_rdata_o));

/* tb/cfgma_core_tb.sv */
// Self-checking bench of the message interpreter core.
// Assumes the replier model takes replies and the checker is bound.
`include "cfgma_defines.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module cfgma_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_n_i = 0, rx_valid_i = 0, rx_ctrl_i = 0, tx_ready_i, slow = 0;
    logic ps_valid_i = 0, ps_write_i = 0, rx_ready_o, tx_valid_o, tx_ctrl_o;
    logic [7:0] rx_data_i = 0, ps_reg_i = 0, tx_data_o, r;
    logic [31:0] rx_dest_i = 0, ps_wdata_i = 0, ps_rdata_o, w, dst;
    logic [15:0] ps_res_o;
    logic [23:0] tx_dest_o, ret;
    logic [32:0] exp[$], e;
    int fails = 0, num_checks = 0, cyc = 0;
    initial forever #20 clk_i = ~clk_i;
    cfgma_core cfgma_core_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .rx_valid_i(rx_valid_i),
        .rx_ctrl_i(rx_ctrl_i), .rx_data_i(rx_data_i), .rx_dest_i(rx_dest_i),
        .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_ctrl_o(tx_ctrl_o),
        .tx_data_o(tx_data_o), .tx_dest_o(tx_dest_o), .tx_ready_i(tx_ready_i),
        .ps_valid_i(ps_valid_i), .ps_write_i(ps_write_i), .ps_reg_i(ps_reg_i),
        .ps_wdata_i(ps_wdata_i), .ps_res_o(ps_res_o), .ps_rdata_o(ps_rdata_o));
    cfgma_replier cfgma_replier_inst (.clk_i(clk_i), .slow_i(slow), .tx_ready_o(tx_ready_i));
    task tally_and_finish;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish;
        end
        if (rst_n_i && tx_valid_o && tx_ready_i) begin
            if (exp.size() == 0) `CHK({tx_ctrl_o, tx_data_o}, 9'h1ff)
            else begin
                e = exp.pop_front();
                `CHK({tx_dest_o, tx_ctrl_o, tx_data_o}, e)
            end
        end
    end
    task tok(input logic c, input logic [7:0] d);
        @(negedge clk_i);
        rx_valid_i = 1;
        rx_ctrl_i = c;
        rx_data_i = d;
        rx_dest_i = dst;
        while (rx_ready_o !== 1'b1) @(negedge clk_i);
        @(posedge clk_i);
    endtask
    task msg(input logic [7:0] lead, input logic [7:0] b[$]);
        tok(1, lead);
        foreach (b[i]) tok(0, b[i]);
        tok(1, `CFGMA_TOK_END);
        @(negedge clk_i);
        rx_valid_i = 0;
        rx_ctrl_i = ~rx_ctrl_i;
        rx_data_i = ~rx_data_i;
    endtask
    task ok(input int n, input logic [31:0] v);
        exp.push_back({ret, 1'b1, `CFGMA_TOK_ACK});
        for (int i = n - 1; i >= 0; i--) exp.push_back({ret, 1'b0, v[8*i+:8]});
        exp.push_back({ret, 1'b1, `CFGMA_TOK_END});
    endtask
    task nak;
        exp.push_back({ret, 1'b1, `CFGMA_TOK_NAK});
        exp.push_back({ret, 1'b1, `CFGMA_TOK_END});
    endtask
    initial begin
        void'($urandom(32'h9e65));
        repeat (3) @(posedge clk_i);
        @(negedge clk_i) rst_n_i = 1;
        for (int k = 0; k < 20; k++) begin
            r = 8'($urandom % 16);
            w = $urandom;
            ret = 24'($urandom);
            ret[0] = 1'b0;
            slow = k[1];
            dst = {16'($urandom), k[0] ? `CFGMA_DEST_NODE : `CFGMA_DEST_TILE};
            if (k % 5 == 0) ret[7:0] = `CFGMA_NO_REPLY;
            else ok(0, 0);
            msg(8'hc0, '{ret[23:16], ret[15:8], ret[7:0], 8'h00, r, w[31:24], w[23:16],
                w[15:8], w[7:0]});
            ok(4, w);
            msg(8'hc1, '{ret[23:16], ret[15:8], ret[7:0], 8'h00, r});
        end
        nak;
        msg(8'hc0, '{ret[23:16], ret[15:8], ret[7:0], 8'h00, 8'h10, 8'h1, 8'h2, 8'h3, 8'h4});
        nak;
        msg(8'h55, '{ret[23:16], ret[15:8], ret[7:0]});
        nak;
        msg(8'hc1, '{ret[23:16], ret[15:8], ret[7:0], 8'h00, r, 8'h5a});
        nak;
        msg(8'h24, '{ret[23:16], ret[15:8], ret[7:0], r, 8'h01, 8'h11});
        dst = {16'h0001, 8'h07, `CFGMA_DEST_PER};
        r = 8'($urandom % 120);
        w = $urandom;
        ok(0, 0);
        msg(8'h24, '{ret[23:16], ret[15:8], ret[7:0], r, 8'h04, w[31:24], w[23:16],
            w[15:8], w[7:0]});
        ok(4, w);
        msg(8'h25, '{ret[23:16], ret[15:8], ret[7:0], r, 8'h04});
        ok(1, {24'h0, w[31:24]});
        msg(8'h25, '{ret[23:16], ret[15:8], ret[7:0], r, 8'h01});
        nak;
        msg(8'h25, '{ret[23:16], ret[15:8], ret[7:0], 8'h7e, 8'h04});
        // A failed write is answered even when the return field asks for silence.
        ret[7:0] = `CFGMA_NO_REPLY;
        nak;
        msg(8'hc0, '{ret[23:16], ret[15:8], ret[7:0], 8'h00, r, w[31:24], w[23:16],
            w[15:8], w[7:0]});
        @(negedge clk_i);
        ps_valid_i = 1;
        ps_write_i = 1;
        ps_reg_i = 8'($urandom);
        ps_wdata_i = $urandom;
        @(negedge clk_i);
        ps_write_i = 0;
        @(negedge clk_i);
        ps_valid_i = 0;
        `CHK(ps_rdata_o, ps_wdata_i)
        `CHK(ps_res_o, {ps_reg_i, 8'h0c})
        for (int i = 0; i < 300 && exp.size() > 0; i++) @(posedge clk_i);
        `CHK(exp.size(), 0)
        tally_and_finish;
    end
endmodule // cfgma_core_tb

/* tb/cfgma_replier.sv */
// Reply consumer standing in for the remote channel-end.
// Assumes the core holds each reply token until it is taken.
module cfgma_replier (
    input wire logic clk_i,
    input wire logic slow_i,
    output logic tx_ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Random stalls when slow, so that held reply tokens are exercised.
    always @(negedge clk_i) tx_ready_o <= slow_i ? 1'($urandom % 3 == 0) : 1'b1;
endmodule // cfgma_replier
